// ---- pkg/ctsr_pkg.sv ----
package ctsr_pkg;

  // register byte offsets
  localparam logic [5:0] ADDR_CTRL    = 6'h00;
  localparam logic [5:0] ADDR_CHANCNT = 6'h04;
  localparam logic [5:0] ADDR_TXTYPE  = 6'h08;
  localparam logic [5:0] ADDR_EVTIMER = 6'h0C;
  localparam logic [5:0] ADDR_NODE    = 6'h10;
  localparam logic [5:0] ADDR_ADCCFG  = 6'h14;
  localparam logic [5:0] ADDR_SEL     = 6'h18;
  localparam logic [5:0] ADDR_RESVAL  = 6'h1C;
  localparam logic [5:0] ADDR_TEMPVAL = 6'h20;
  localparam logic [5:0] ADDR_RAWVAL  = 6'h24;
  localparam logic [5:0] ADDR_UVOLT   = 6'h28;
  localparam logic [5:0] ADDR_STATUS  = 6'h2C;

  // control register fields
  localparam int CTRL_UNIT_BIT  = 0;
  localparam int CTRL_RECAL_BIT = 1;
  localparam int CTRL_OPER_BIT  = 2;
  localparam int CTRL_SAVE_BIT  = 3;

  // reset values and channel count limit
  localparam logic       UNIT_TEMP_RST = 1'b1;
  localparam logic [6:0] CHANCNT_RST   = 7'h40;
  localparam logic [6:0] CHANCNT_MAX   = 7'h40;
  localparam logic [7:0] EVTIMER_RST   = 8'h00;
  localparam logic [6:0] ADCCFG_RST    = 7'h00;

  // can identifiers and transmission types
  localparam logic [10:0] SYNC_ID      = 11'h080;
  localparam logic [10:0] EMCY_BASE    = 11'h080;
  localparam logic [10:0] TPDO2_BASE   = 11'h280;
  localparam logic [7:0]  TX_TYPE_SYNC = 8'h01;
  localparam logic [7:0]  TX_TYPE_RTR  = 8'hFF;

  // flags byte constant upper nibble
  localparam logic [3:0] RAW_FLAG_HI = 4'hE;

  // conversion constants
  localparam logic [13:0] RES_SCALE    = 14'h2710;
  localparam logic [23:0] TEMP_INVALID = 24'hFFFFFF;
  localparam logic [15:0] RES_MAX      = 16'hFFFF;
  localparam logic [21:0] UV_FULL      = 22'h2625A0;
  localparam int          DIV_STEPS    = 30;
  localparam int          SLOPE_SHIFT  = 8;

  // ntc breakpoints, ohms and millidegrees
  localparam int TBL_R0 = 16369;
  localparam int TBL_R1 = 5000;
  localparam int TBL_R2 = 1801;
  localparam int TBL_R3 = 743;
  localparam int TBL_R4 = 341;
  localparam int TBL_T0 = 0;
  localparam int TBL_T1 = 25000;
  localparam int TBL_T2 = 50000;
  localparam int TBL_T3 = 75000;
  localparam int TBL_STEP = 25000;
  localparam int SLOPE0 = (TBL_STEP * 256) / (TBL_R0 - TBL_R1);
  localparam int SLOPE1 = (TBL_STEP * 256) / (TBL_R1 - TBL_R2);
  localparam int SLOPE2 = (TBL_STEP * 256) / (TBL_R2 - TBL_R3);
  localparam int SLOPE3 = (TBL_STEP * 256) / (TBL_R3 - TBL_R4);

  // timing
  localparam int CLK_HZ      = 25000000;
  localparam int TICK_S      = 1;
  localparam int TICK_CYCLES = CLK_HZ * TICK_S;

  typedef enum logic [2:0] {
    ST_INIT, ST_IDLE, ST_CAL, ST_REQ, ST_WAIT, ST_DIV, ST_SEND
  } ctsr_state_t;

endpackage

// ---- src/ctsr_readout.sv ----
// Chosen here: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
// Functional notes
// - one four-byte message per sensor, id 280h+node
// - channel count up to 64, sensors half
// - even channel voltage, odd current, divide, convert
// - temperature mode: index, 24-bit millidegrees, invalid all-ones
// - resistance mode: index, status+config, 16-bit ohms
// - resistance mode index field stays in range
// - status bit7 error, bits6-0 converter config
// - unit defaults to temperature after reset
// - type 1: sync starts full scan
// - type 255: own remote frame starts scan
// - nonzero seconds timer starts periodic scans too
// - transmission type writable, saved value reloads
// - optional converter recalibration before each scan
// - single sensor ohms and temperature readable
// - single input raw counts or microvolts readable
// - raw flags byte 1110, channel, oscillation, overrange
// - sensors 30, 31 are reference resistors
// - converter faults raise emergency messages
// - fixed identifiers and fixed message content
// - remote frame honoured only for own node
// - timer scans only while operational
module ctsr_readout
  import ctsr_pkg::*;
#(
  parameter int          TICK_COUNT = TICK_CYCLES,
  parameter logic [6:0]  NODE_RST   = 7'h01,
  parameter logic [15:0] EMCY_CODE  = 16'h5000
)(
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        canRxValid,
  input  wire logic [10:0] canRxId,
  input  wire logic        canRxRtr,
  input  wire logic [3:0]  canRxDlc,
  output logic             txValid,
  output logic      [10:0] txId,
  output logic      [31:0] txData,
  input  wire logic        txReady,
  output logic             emcyValid,
  output logic      [10:0] emcyId,
  output logic      [15:0] emcyCode,
  input  wire logic        emcyReady,
  output logic             adcReq,
  output logic             adcCalReq,
  output logic      [5:0]  adcChan,
  output logic      [6:0]  adcCfg,
  input  wire logic        adcAck,
  input  wire logic [15:0] adcCount,
  input  wire logic [1:0]  adcPhysChan,
  input  wire logic        oscillation_flag,
  input  wire logic        overrange_flag,
  input  wire logic        adcFault,
  input  wire logic [7:0]  nvTxType,
  output logic             nvSave,
  output logic      [7:0]  nvSaveData
);

  function automatic logic [31:0] beMerge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[i*8 +: 8] = wd[i*8 +: 8];
    return r;
  endfunction

  function automatic logic [23:0] interp(input logic [15:0] r, input int rHi, input int tLo, input int slope);
    int d;
    d = (rHi - int'(r)) * slope;
    return 24'(tLo + (d >>> SLOPE_SHIFT));
  endfunction

  ctsr_state_t state_q;
  logic        unitTemp_q;
  logic        recalEn_q;
  logic        oper_q;
  logic [6:0]  chanCnt_q;
  logic [7:0]  txType_q;
  logic [7:0]  evTimer_q;
  logic [6:0]  node_q;
  logic [6:0]  adcCfg_q;
  logic [5:0]  sel_q;
  logic [31:0] readdata_q;
  logic        waitreq_q;
  logic        nvSave_q;
  logic [7:0]  nvSaveData_q;
  logic        txValid_q;
  logic [10:0] txId_q;
  logic [31:0] txData_q;
  logic        emcyValid_q;
  logic [10:0] emcyId_q;
  logic        adcReq_q;
  logic        adcCal_q;
  logic [5:0]  adcChan_q;
  logic        oddPhase_q;
  logic [4:0]  sensor_q;
  logic        scanPend_q;
  logic [31:0] tick_q;
  logic [7:0]  secCnt_q;
  logic [15:0] cntV_q;
  logic        errV_q;
  logic        errI_q;
  logic [29:0] rem_q;
  logic [29:0] quo_q;
  logic [29:0] num_q;
  logic [15:0] den_q;
  logic [4:0]  divCnt_q;
  logic [15:0] scans_q;
  logic [15:0] resMem_q  [32];
  logic [23:0] tempMem_q [32];
  logic [15:0] rawMem_q  [64];
  logic [7:0]  flagMem_q [64];

  // bus decode
  wire        busAccept = (avs_read | avs_write) & waitreq_q;
  wire        wrNow     = avs_write & ~waitreq_q;
  wire [31:0] wdCtrl    = beMerge({28'h0, 1'b0, oper_q, recalEn_q, unitTemp_q}, avs_writedata, avs_byteenable);
  wire [31:0] wdChan    = beMerge({25'h0, chanCnt_q}, avs_writedata, avs_byteenable);
  wire [31:0] wdType    = beMerge({24'h0, txType_q}, avs_writedata, avs_byteenable);
  wire [31:0] wdTimer   = beMerge({24'h0, evTimer_q}, avs_writedata, avs_byteenable);
  wire [31:0] wdNode    = beMerge({25'h0, node_q}, avs_writedata, avs_byteenable);
  wire [31:0] wdCfg     = beMerge({25'h0, adcCfg_q}, avs_writedata, avs_byteenable);
  wire [31:0] wdSel     = beMerge({26'h0, sel_q}, avs_writedata, avs_byteenable);
  wire        wrCtrl    = wrNow & (avs_address == ADDR_CTRL);
  wire        wrType    = wrNow & (avs_address == ADDR_TXTYPE);
  wire        saveReq   = wrCtrl & wdCtrl[CTRL_SAVE_BIT];
  wire [6:0]  chanClamp = (wdChan[6:0] > CHANCNT_MAX) ? CHANCNT_MAX : wdChan[6:0];

  // sdo-style single value reads
  wire [15:0] selRaw  = rawMem_q[sel_q];
  wire [37:0] uvProd  = 38'(selRaw) * 38'(UV_FULL);
  wire [21:0] selUv   = uvProd[37:16];
  logic [31:0] rdMux;
  always_comb
  begin
    case (avs_address)
      ADDR_CTRL:    rdMux = {28'h0, 1'b0, oper_q, recalEn_q, unitTemp_q};
      ADDR_CHANCNT: rdMux = {25'h0, chanCnt_q};
      ADDR_TXTYPE:  rdMux = {24'h0, txType_q};
      ADDR_EVTIMER: rdMux = {24'h0, evTimer_q};
      ADDR_NODE:    rdMux = {25'h0, node_q};
      ADDR_ADCCFG:  rdMux = {25'h0, adcCfg_q};
      ADDR_SEL:     rdMux = {26'h0, sel_q};
      ADDR_RESVAL:  rdMux = {16'h0, resMem_q[sel_q[4:0]]};
      ADDR_TEMPVAL: rdMux = {8'h0, tempMem_q[sel_q[4:0]]};
      ADDR_RAWVAL:  rdMux = {8'h0, flagMem_q[sel_q], selRaw};
      ADDR_UVOLT:   rdMux = {flagMem_q[sel_q], 2'h0, selUv};
      ADDR_STATUS:  rdMux = {scans_q, 2'h0, scanPend_q, sensor_q, 5'h0, state_q};
      default:      rdMux = 32'h0;
    endcase
  end

  // trigger decode
  wire [10:0] ownTpdo  = TPDO2_BASE + {4'h0, node_q};
  wire        isSync   = canRxValid & ~canRxRtr & (canRxId == SYNC_ID) & (canRxDlc == 4'h0);
  wire        isRemote = canRxValid & canRxRtr & (canRxId == ownTpdo) & (canRxDlc == 4'h0);
  wire        syncTrig = isSync & (txType_q == TX_TYPE_SYNC);
  wire        rtrTrig  = isRemote & (txType_q == TX_TYPE_RTR);
  wire        tickNow  = (tick_q == 32'(TICK_COUNT - 1));
  wire        secHit   = tickNow & (secCnt_q == evTimer_q - 8'h01);
  wire        timeTrig = secHit & oper_q & (evTimer_q != 8'h00);
  wire        anyTrig  = syncTrig | rtrTrig | timeTrig;
  wire [5:0]  sensorCnt = chanCnt_q[6:1];
  wire        lastSens = ({1'b0, sensor_q} + 6'h01 >= sensorCnt);

  // resistance and temperature of current pair
  wire        divZero  = (den_q == 16'h0);
  wire        resOvf   = divZero | (quo_q > 30'(RES_MAX));
  wire [15:0] resVal   = resOvf ? RES_MAX : quo_q[15:0];
  wire [15:0] r        = resVal;
  logic [23:0] tempVal;
  always_comb
  begin
    // reference resistors at positions 30 and 31 land on the end points
    if (resOvf | errV_q | errI_q | r > 16'(TBL_R0) | r < 16'(TBL_R4))
      tempVal = TEMP_INVALID;
    else if (r > 16'(TBL_R1))
      tempVal = interp(r, TBL_R0, TBL_T0, SLOPE0);
    else if (r > 16'(TBL_R2))
      tempVal = interp(r, TBL_R1, TBL_T1, SLOPE1);
    else if (r > 16'(TBL_R3))
      tempVal = interp(r, TBL_R2, TBL_T2, SLOPE2);
    else
      tempVal = interp(r, TBL_R3, TBL_T3, SLOPE3);
  end
  wire [7:0]  statusB  = {errI_q | errV_q, adcCfg_q};
  wire [7:0]  idxByte  = {3'h0, sensor_q};
  wire [31:0] msgTemp  = {tempVal, idxByte};
  wire [31:0] msgRes   = {resVal, statusB, idxByte};

  // dividend and divisor step
  wire [30:0] remShift = {rem_q, num_q[29]};
  wire        subOk    = remShift >= 31'(den_q);
  wire [30:0] remSub   = remShift - 31'(den_q);

  // bus slave: waitrequest drops one cycle after the request
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      waitreq_q  <= 1'b1;
      readdata_q <= 32'h0;
    end
    else
    begin
      waitreq_q  <= ~busAccept;
      if (busAccept)
        readdata_q <= avs_read ? rdMux : 32'h0;
    end
  end

  // software registers
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      unitTemp_q <= UNIT_TEMP_RST;
      recalEn_q  <= 1'b0;
      oper_q     <= 1'b0;
      chanCnt_q  <= CHANCNT_RST;
      evTimer_q  <= EVTIMER_RST;
      node_q     <= NODE_RST;
      adcCfg_q   <= ADCCFG_RST;
      sel_q      <= 6'h0;
    end
    else if (wrNow)
    begin
      case (avs_address)
        ADDR_CTRL:
        begin
          unitTemp_q <= wdCtrl[CTRL_UNIT_BIT];
          recalEn_q  <= wdCtrl[CTRL_RECAL_BIT];
          oper_q     <= wdCtrl[CTRL_OPER_BIT];
        end
        ADDR_CHANCNT: chanCnt_q <= chanClamp;
        ADDR_EVTIMER: evTimer_q <= wdTimer[7:0];
        ADDR_NODE:    node_q    <= wdNode[6:0];
        ADDR_ADCCFG:  adcCfg_q  <= wdCfg[6:0];
        ADDR_SEL:     sel_q     <= wdSel[5:0];
        default:      sel_q     <= sel_q;
      endcase
    end
  end

  // transmission type: stored default is taken once reset is released
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      txType_q     <= TX_TYPE_RTR;
      nvSave_q     <= 1'b0;
      nvSaveData_q <= 8'h0;
      emcyId_q     <= 11'h0;
    end
    else
    begin
      nvSave_q <= saveReq;
      emcyId_q <= EMCY_BASE + {4'h0, node_q};
      if (state_q == ST_INIT)
        txType_q <= nvTxType;
      else if (wrType)
        txType_q <= wdType[7:0];
      if (saveReq)
        nvSaveData_q <= wrType ? wdType[7:0] : txType_q;
    end
  end

  // one second tick and event timer
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      tick_q   <= 32'h0;
      secCnt_q <= 8'h0;
    end
    else
    begin
      tick_q <= tickNow ? 32'h0 : tick_q + 32'h1;
      if (secHit | evTimer_q == 8'h00)
        secCnt_q <= 8'h0;
      else if (tickNow)
        secCnt_q <= secCnt_q + 8'h01;
    end
  end

  // emergency on converter fault, held until taken
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      emcyValid_q <= 1'b0;
    else if (adcFault)
      emcyValid_q <= 1'b1;
    else if (emcyReady)
      emcyValid_q <= 1'b0;
  end

  // scan sequencer
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q    <= ST_INIT;
      scanPend_q <= 1'b0;
      sensor_q   <= 5'h0;
      oddPhase_q <= 1'b0;
      adcReq_q   <= 1'b0;
      adcCal_q   <= 1'b0;
      adcChan_q  <= 6'h0;
      cntV_q     <= 16'h0;
      errV_q     <= 1'b0;
      errI_q     <= 1'b0;
      rem_q      <= 30'h0;
      quo_q      <= 30'h0;
      num_q      <= 30'h0;
      den_q      <= 16'h0;
      divCnt_q   <= 5'h0;
      txValid_q  <= 1'b0;
      txId_q     <= 11'h0;
      txData_q   <= 32'h0;
      scans_q    <= 16'h0;
    end
    else
    begin
      adcReq_q <= 1'b0;
      adcCal_q <= 1'b0;
      // a trigger during a scan is remembered, not lost
      if (anyTrig)
        scanPend_q <= 1'b1;
      case (state_q)
        ST_INIT: state_q <= ST_IDLE;
        ST_IDLE:
          if ((scanPend_q | anyTrig) && sensorCnt != 6'h0)
          begin
            scanPend_q <= 1'b0;
            sensor_q   <= 5'h0;
            oddPhase_q <= 1'b0;
            if (recalEn_q)
            begin
              adcCal_q <= 1'b1;
              state_q  <= ST_CAL;
            end
            else
              state_q <= ST_REQ;
          end
        ST_CAL:
          if (adcAck)
            state_q <= ST_REQ;
        ST_REQ:
        begin
          adcChan_q <= {sensor_q, oddPhase_q};
          adcReq_q  <= 1'b1;
          state_q   <= ST_WAIT;
        end
        ST_WAIT:
          if (adcAck)
          begin
            if (!oddPhase_q)
            begin
              cntV_q     <= adcCount;
              errV_q     <= oscillation_flag | overrange_flag;
              oddPhase_q <= 1'b1;
              state_q    <= ST_REQ;
            end
            else
            begin
              errI_q   <= oscillation_flag | overrange_flag;
              num_q    <= 30'(cntV_q) * 30'(RES_SCALE);
              den_q    <= adcCount;
              rem_q    <= 30'h0;
              quo_q    <= 30'h0;
              divCnt_q <= 5'h0;
              state_q  <= ST_DIV;
            end
          end
        ST_DIV:
        begin
          rem_q    <= subOk ? remSub[29:0] : remShift[29:0];
          quo_q    <= {quo_q[28:0], subOk};
          num_q    <= {num_q[28:0], 1'b0};
          divCnt_q <= divCnt_q + 5'h01;
          if (divCnt_q == 5'(DIV_STEPS - 1))
            state_q <= ST_SEND;
        end
        ST_SEND:
          if (!txValid_q)
          begin
            txValid_q <= 1'b1;
            txId_q    <= ownTpdo;
            txData_q  <= unitTemp_q ? msgTemp : msgRes;
          end
          else if (txReady)
          begin
            txValid_q  <= 1'b0;
            oddPhase_q <= 1'b0;
            if (lastSens)
            begin
              scans_q <= scans_q + 16'h0001;
              state_q <= ST_IDLE;
            end
            else
            begin
              sensor_q <= sensor_q + 5'h01;
              state_q  <= ST_REQ;
            end
          end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // per-sensor and per-input result storage
  wire storeRaw  = (state_q == ST_WAIT) & adcAck;
  wire storeSens = (state_q == ST_SEND) & ~txValid_q;
  always_ff @(posedge clk_sys)
  begin
    if (storeRaw)
    begin
      rawMem_q[adcChan_q]  <= adcCount;
      flagMem_q[adcChan_q] <= {RAW_FLAG_HI, adcPhysChan, oscillation_flag, overrange_flag};
    end
    if (storeSens)
    begin
      resMem_q[sensor_q]  <= resVal;
      tempMem_q[sensor_q] <= tempVal;
    end
  end

  assign avs_readdata    = readdata_q;
  assign avs_waitrequest = waitreq_q;
  assign txValid         = txValid_q;
  assign txId            = txId_q;
  assign txData          = txData_q;
  assign emcyValid       = emcyValid_q;
  assign emcyId          = emcyId_q;
  assign emcyCode        = EMCY_CODE;
  assign adcReq          = adcReq_q;
  assign adcCalReq       = adcCal_q;
  assign adcChan         = adcChan_q;
  assign adcCfg          = adcCfg_q;
  assign nvSave          = nvSave_q;
  assign nvSaveData      = nvSaveData_q;

endmodule

// ---- sim/ctsr_readout_assertions.sv ----
`timescale 1ns/1ps
module ctsr_readout_assertions (
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  input wire logic        txValid,
  input wire logic [10:0] txId,
  input wire logic [31:0] txData,
  input wire logic        txReady,
  input wire logic        emcyValid,
  input wire logic [10:0] emcyId,
  input wire logic        emcyReady,
  input wire logic        adcReq,
  input wire logic [5:0]  adcChan,
  input wire logic        nvSave
);
  logic [4:0] lastSens_q;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // all ones so the first even request after reset wraps to sensor 0
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
      lastSens_q <= 5'h1F;
    else if (adcReq)
      lastSens_q <= adcChan[5:1];
  property p_wait_ans;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_ans: assert property (p_wait_ans) else $error("bus request not answered in time");
  property p_wait_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
  property p_tx_hold;
    txValid && !txReady |=> txValid && $stable(txData) && $stable(txId);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("message dropped or changed while stalled");
  property p_tx_id;
    txValid |-> txId[10:7] == 4'h5 && txId[6:0] != 7'h00;
  endproperty
  a_tx_id: assert property (p_tx_id) else $error("message identifier outside its set");
  property p_idx;
    txValid |-> txData[7:5] == 3'h0;
  endproperty
  a_idx: assert property (p_idx) else $error("sensor index out of range");
  property p_emcy_id;
    emcyValid |-> emcyId[10:7] == 4'h1 && emcyId[6:0] != 7'h00;
  endproperty
  a_emcy_id: assert property (p_emcy_id) else $error("emergency identifier wrong");
  property p_emcy_hold;
    emcyValid && !emcyReady |=> emcyValid;
  endproperty
  a_emcy_hold: assert property (p_emcy_hold) else $error("emergency dropped before taken");
  property p_pair;
    adcReq && adcChan[0] |-> adcChan[5:1] == lastSens_q;
  endproperty
  a_pair: assert property (p_pair) else $error("odd channel not paired with even");
  property p_order;
    adcReq && !adcChan[0] |-> adcChan[5:1] == 5'h00 || adcChan[5:1] == lastSens_q + 5'h01;
  endproperty
  a_order: assert property (p_order) else $error("sensor order broken");
  property p_tx_after_odd;
    $rose(txValid) |-> adcChan[0];
  endproperty
  a_tx_after_odd: assert property (p_tx_after_odd) else $error("message before current conversion");
  property p_nv;
    nvSave |=> !nvSave;
  endproperty
  a_nv: assert property (p_nv) else $error("save pulse too long");
  cover property (txValid && txReady);
  cover property (emcyValid && emcyReady);
  cover property (nvSave);
endmodule

// ---- sim/ctsr_adc_model.sv ----
`timescale 1ns/1ps
module ctsr_adc_model (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        slow,
  input  wire logic [4:0]  errSensor,
  input  wire logic        adcReq,
  input  wire logic        adcCalReq,
  input  wire logic [5:0]  adcChan,
  output logic             adcAck,
  output logic      [15:0] adcCount,
  output logic      [1:0]  adcPhysChan,
  output logic             oscillation_flag,
  output logic             overrange_flag,
  output logic             txReady
);
  logic       busy;
  logic       cal;
  logic [3:0] waitCnt;
  logic [5:0] ch;
  logic       bad;
  assign bad = !cal && ch[5:1] == errSensor;
  always @(posedge clk_sys or negedge nrst)
    if (!nrst)
    begin
      busy <= 1'b0;
      adcAck <= 1'b0;
      txReady <= 1'b0;
    end
    else
    begin
      adcAck <= 1'b0;
      txReady <= slow ? ($urandom % 3 == 0) : 1'b1;
      // off the strobe the results toggle so a stale read shows
      adcCount <= ~adcCount;
      oscillation_flag <= ~oscillation_flag;
      overrange_flag <= ~overrange_flag;
      if (adcReq || adcCalReq)
      begin
        busy <= 1'b1;
        cal <= adcCalReq;
        ch <= adcChan;
        waitCnt <= slow ? 4'($urandom_range(9, 3)) : 4'h0;
      end
      else if (busy && waitCnt != 4'h0)
        waitCnt <= waitCnt - 4'h1;
      else if (busy)
      begin
        busy <= 1'b0;
        adcAck <= 1'b1;
        adcCount <= ch[0] ? 16'h03E8 : {10'h000, ch} * 16'h0064 + 16'h0064;
        adcPhysChan <= ch[1:0];
        oscillation_flag <= bad && ch[0];
        overrange_flag <= bad && !ch[0];
      end
    end
endmodule

// ---- sim/can_temperature_sensor_readout_tb.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; $display("unexpected at %0t: %h vs %h", $time, (a), (b)); end end
module can_temperature_sensor_readout_tb;
  import ctsr_pkg::*;
  logic        clk_sys, nrst, avs_read, avs_write, avs_waitrequest, canRxValid, canRxRtr, txValid, txReady;
  logic        emcyValid, emcyReady, adcReq, adcCalReq, adcAck, oscillation_flag, overrange_flag, adcFault;
  logic        nvSave, slow;
  logic [5:0]  avs_address, adcChan;
  logic [31:0] avs_writedata, avs_readdata, txData, rd;
  logic [3:0]  canRxDlc;
  logic [10:0] canRxId, txId, emcyId;
  logic [15:0] emcyCode, adcCount;
  logic [1:0]  adcPhysChan;
  logic [6:0]  adcCfg, node, cfg;
  logic [7:0]  nvTxType, nvSaveData, saved;
  logic [4:0]  errS;
  int          num_errors, checked, txSeen, calSeen, n, c;
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  ctsr_readout #(.TICK_COUNT(20)) uut (.clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .canRxValid(canRxValid),
    .canRxId(canRxId), .canRxRtr(canRxRtr), .canRxDlc(canRxDlc), .txValid(txValid), .txId(txId),
    .txData(txData), .txReady(txReady), .emcyValid(emcyValid), .emcyId(emcyId), .emcyCode(emcyCode),
    .emcyReady(emcyReady), .adcReq(adcReq), .adcCalReq(adcCalReq), .adcChan(adcChan), .adcCfg(adcCfg),
    .adcAck(adcAck), .adcCount(adcCount), .adcPhysChan(adcPhysChan), .oscillation_flag(oscillation_flag),
    .overrange_flag(overrange_flag), .adcFault(adcFault), .nvTxType(nvTxType), .nvSave(nvSave),
    .nvSaveData(nvSaveData));
  ctsr_adc_model far (.clk_sys(clk_sys), .nrst(nrst), .slow(slow), .errSensor(errS), .adcReq(adcReq),
    .adcCalReq(adcCalReq), .adcChan(adcChan), .adcAck(adcAck), .adcCount(adcCount),
    .adcPhysChan(adcPhysChan), .oscillation_flag(oscillation_flag), .overrange_flag(overrange_flag),
    .txReady(txReady));
  always @(posedge clk_sys)
  begin
    if (txValid && txReady)
      txSeen++;
    if (adcCalReq)
      calSeen++;
    if (nvSave)
      saved = nvSaveData;
  end
  task automatic conclude();
    if (num_errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_write <= wr;
    avs_read <= !wr;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge clk_sys); while (avs_waitrequest);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic frame(input logic [10:0] id, input logic rtr);
    @(posedge clk_sys);
    canRxValid <= 1'b1;
    canRxId <= id;
    canRxRtr <= rtr;
    canRxDlc <= 4'h0;
    @(posedge clk_sys);
    canRxValid <= 1'b0;
  endtask
  task automatic collect(input int k, input logic temp);
    logic [15:0] r;
    for (int s = 0; s < k; s++)
    begin
      do @(negedge clk_sys); while (!(txValid && txReady));
      r = 16'(2000 * s + 1000);
      `CHK(txId, TPDO2_BASE + 11'(node))
      `CHK(txData[7:0], 8'(s))
      if (temp)
        `CHK(txData[31:8] === TEMP_INVALID, s == errS || r > 16369)
      else
        `CHK(txData[31:8], {r, s == errS, cfg})
      @(posedge clk_sys);
    end
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    conclude();
  end
  initial
  begin
    void'($urandom(32'hE7C30EFF));
    {nrst, avs_read, avs_write, canRxValid, canRxRtr, emcyReady, adcFault, slow} = '0;
    avs_address = '0;
    avs_writedata = '0;
    canRxId = '0;
    canRxDlc = '0;
    errS = 5'h1F;
    node = 7'h01;
    cfg = 7'($urandom);
    nvTxType = ($urandom % 2) ? TX_TYPE_SYNC : TX_TYPE_RTR;
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    bus(1'b0, ADDR_CTRL, 32'h0);
    `CHK(rd[CTRL_UNIT_BIT], UNIT_TEMP_RST)
    bus(1'b0, ADDR_CHANCNT, 32'h0);
    `CHK(rd[6:0], CHANCNT_RST)
    bus(1'b0, ADDR_TXTYPE, 32'h0);
    `CHK(rd[7:0], nvTxType)
    bus(1'b0, 6'h3C, 32'h0);
    `CHK(rd, 32'h0)
    bus(1'b1, ADDR_TXTYPE, 32'h1);
    bus(1'b1, ADDR_CTRL, 32'h8);
    repeat (2) @(posedge clk_sys);
    `CHK(saved, TX_TYPE_SYNC)
    n = 2 * (2 + $urandom % 5);
    node = 7'($urandom_range(127, 1));
    errS <= 5'($urandom % (n / 2));
    slow <= 1'b1;
    bus(1'b1, ADDR_CHANCNT, 32'(n));
    bus(1'b1, ADDR_NODE, 32'(node));
    bus(1'b1, ADDR_ADCCFG, 32'(cfg));
    frame(SYNC_ID, 1'b0);
    `CHK(adcCfg, cfg)
    collect(n / 2, 1'b0);
    bus(1'b1, ADDR_CHANCNT, 32'h7F);
    bus(1'b0, ADDR_CHANCNT, 32'h0);
    `CHK(rd[6:0], CHANCNT_MAX)
    bus(1'b1, ADDR_CHANCNT, 32'd20);
    bus(1'b1, ADDR_TXTYPE, 32'hFF);
    bus(1'b1, ADDR_CTRL, 32'h3);
    errS <= 5'($urandom % 3);
    c = calSeen;
    frame(TPDO2_BASE + 11'(node) + 11'h1, 1'b1);
    frame(SYNC_ID, 1'b0);
    frame(TPDO2_BASE + 11'(node), 1'b1);
    collect(10, 1'b1);
    bus(1'b0, ADDR_STATUS, 32'h0);
    `CHK({rd[31:13], rd[2:0]}, {19'h10, 3'(ST_IDLE)})
    `CHK(calSeen > c, 1'b1)
    bus(1'b1, ADDR_SEL, 32'd9);
    bus(1'b0, ADDR_RESVAL, 32'h0);
    `CHK(rd[15:0], 16'd19000)
    bus(1'b0, ADDR_TEMPVAL, 32'h0);
    `CHK(rd[23:0], TEMP_INVALID)
    bus(1'b0, ADDR_RAWVAL, 32'h0);
    `CHK(rd[23:0], {RAW_FLAG_HI, 2'b01, 2'b00, 16'h03E8})
    bus(1'b0, ADDR_UVOLT, 32'h0);
    `CHK(rd, {RAW_FLAG_HI, 4'h4, 2'b00, 22'((64'd1000 * 64'd2500000) >> 16)})
    slow <= 1'b0;
    errS <= 5'h1F;
    bus(1'b1, ADDR_CHANCNT, 32'd4);
    bus(1'b1, ADDR_CTRL, 32'h0);
    bus(1'b1, ADDR_EVTIMER, 32'd2);
    c = txSeen;
    repeat (100) @(posedge clk_sys);
    `CHK(txSeen, c)
    bus(1'b1, ADDR_CTRL, 32'h4);
    collect(2, 1'b0);
    bus(1'b1, ADDR_EVTIMER, 32'h0);
    @(posedge clk_sys);
    adcFault <= 1'b1;
    @(posedge clk_sys);
    adcFault <= 1'b0;
    do @(negedge clk_sys); while (!emcyValid);
    `CHK(emcyId, EMCY_BASE + 11'(node))
    `CHK(emcyCode, 16'h5000)
    repeat (3) @(posedge clk_sys);
    emcyReady <= 1'b1;
    @(posedge clk_sys);
    emcyReady <= 1'b0;
    conclude();
  end
endmodule
bind ctsr_readout ctsr_readout_assertions chk (.clk_sys(clk_sys), .nrst(nrst), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .txValid(txValid), .txId(txId), .txData(txData),
  .txReady(txReady), .emcyValid(emcyValid), .emcyId(emcyId), .emcyReady(emcyReady), .adcReq(adcReq),
  .adcChan(adcChan), .nvSave(nvSave));
